// >>> rtl/cod_cfg.svh
// constants for the clock output divider block: register map, fields, timing
`ifndef COD_CFG_SVH
`define COD_CFG_SVH
`define COD_OFF_CTRL      8'h00
`define COD_OFF_ALIGN     8'h0C
`define COD_OFF_STATUS    8'h20
`define COD_OFF_INTDIV0   8'h40
`define COD_OFF_FRAC4     8'h60
`define COD_SOFT_ALIGN_BIT 5
`define COD_INT_W         10
`define COD_FRAC_W        20
`define COD_PRE_W         8
`define COD_FRAC_MIN_PRE  8'h02
`define COD_FIRST_EDGE_NS 15
`define COD_CLK_NS        25
`define COD_FIRST_EDGE_CYC ((`COD_FIRST_EDGE_NS + `COD_CLK_NS - 1) / `COD_CLK_NS)
`endif

// >>> rtl/cod_pkg.sv
// types for the clock output divider block
package cod_pkg;
    typedef enum logic [1:0] {COD_RUN, COD_HOLD, COD_RETIME} cod_align_t;
    typedef enum logic [1:0] {COD_BYP_DIV, COD_BYP_PRI, COD_BYP_SEC} cod_bypass_t;
endpackage

// >>> rtl/cod_frac_div.sv
// one fractional divider: integer pre-divider followed by sigma-delta stage
`timescale 1ns/1ps
`include "cod_cfg.svh"
module cod_frac_div (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    hold,
    input  wire logic [`COD_PRE_W-1:0]   pre_div,
    input  wire logic [`COD_FRAC_W-1:0]  frac,
    input  wire logic                    tick_in,
    output logic                         clk_out
);
    logic [`COD_PRE_W-1:0]  count;
    logic [`COD_FRAC_W-1:0] acc;
    logic [`COD_FRAC_W:0]   sum;
    logic [`COD_PRE_W-1:0]  eff_div;
    logic [`COD_PRE_W-1:0]  limit;
    logic                   wrap;

    // settings below two are raised to two
    assign eff_div = (pre_div < `COD_FRAC_MIN_PRE) ? `COD_FRAC_MIN_PRE : pre_div;
    // accumulator carry stretches one period by one input tick
    assign sum   = {1'b0, acc} + {1'b0, frac};
    assign limit = sum[`COD_FRAC_W] ? eff_div : eff_div - 8'h01;
    assign wrap  = tick_in && (count >= limit);

    // pre-divider counter and 20-bit fraction accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn || hold) begin
            count   <= 8'h00;
            acc     <= 20'h00000;
            clk_out <= 1'b0;
        end else if (tick_in) begin
            if (wrap) begin
                count <= 8'h00;
                acc   <= sum[`COD_FRAC_W-1:0];
            end else begin
                count <= count + 8'h01;
            end
            clk_out <= (count < (eff_div >> 1)) ? 1'b1 : 1'b0;
        end
    end
endmodule

// >>> rtl/cod_top.sv
// clock output divider stage with alignment, bypass mux and output enables
// How it works
// - ten-bit continuous integer counter per output
// - outputs four to seven carry fractional dividers
// - fractional divide setting never below two
// - integer pre-divider then sigma-delta stage
// - fraction held in twenty bits
// - align from pin or soft bit
// - align asserted: outputs off, dividers reset
// - release latched, retimed, all enabled together
// - release delay fixed within one tick
// - devices align within one prescaler cycle
// - outputs 0,1,4,5 first prescaler, others second
// - outputs four, five select bypass inputs
`timescale 1ns/1ps
`include "cod_cfg.svh"
module cod_top
    import cod_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        first_prescaler,
    input  wire logic        second_prescaler,
    input  wire logic        primary_in,
    input  wire logic        secondary_in,
    input  wire logic        output_align_request_n,
    output logic [7:0]       clk_out,
    output logic [7:0]       clk_out_oe
);
    import cod_pkg::*;

    // registers
    logic [7:0]             out_enable;
    logic [3:0]             frac_enable;
    logic [1:0]             bypass_sel [2];
    logic                   soft_align_bit;
    logic [`COD_INT_W-1:0]  int_ratio [8];
    logic [`COD_PRE_W-1:0]  frac_pre [4];
    logic [`COD_FRAC_W-1:0] frac_val [4];
    logic                   aw_held;
    logic                   w_held;
    logic [31:0]            aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    cod_align_t             align_state;
    cod_align_t             next_align_state;
    logic [1:0]             retime_cnt;
    logic                   prev_a;
    logic                   prev_b;
    logic [7:0]             int_out;
    logic [3:0]             frac_out;
    logic [`COD_INT_W-1:0]  int_cnt [8];

    // alignment request and prescaler tick detection
    wire align_req = !output_align_request_n || soft_align_bit;
    wire hold_div  = (align_state != COD_RUN);
    wire tick_a    = first_prescaler && !prev_a;
    wire tick_b    = second_prescaler && !prev_b;
    wire [7:0] tick_sel = {tick_b, tick_b, tick_a, tick_a, tick_b, tick_b, tick_a, tick_a};

    // write decode; address and data may arrive in either order
    wire        do_write = aw_held && w_held && !s_axi_bvalid;
    wire [7:0]  w_off    = aw_addr[7:0];
    wire [7:0]  r_off    = s_axi_araddr[7:0];
    wire        w_hit    = (w_off == `COD_OFF_CTRL) || (w_off == `COD_OFF_ALIGN) ||
                           ((w_off >= `COD_OFF_INTDIV0) && (w_off < 8'h60) && (w_off[1:0] == 2'b00)) ||
                           ((w_off >= `COD_OFF_FRAC4) && (w_off < 8'h70) && (w_off[1:0] == 2'b00));

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    // address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 32'h00000000;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response; unmapped offsets answer slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_hit ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers; all outputs disabled out of reset so a host can stagger them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_enable     <= 8'h00;
            frac_enable    <= 4'h0;
            bypass_sel[0]  <= 2'h0;
            bypass_sel[1]  <= 2'h0;
            soft_align_bit <= 1'b0;
        end else if (do_write && w_off == `COD_OFF_CTRL) begin
            if (w_strb[0]) out_enable <= w_data[7:0];
            if (w_strb[1]) frac_enable <= w_data[11:8];
            if (w_strb[2]) begin
                bypass_sel[0] <= w_data[17:16];
                bypass_sel[1] <= w_data[19:18];
            end
        end else if (do_write && w_off == `COD_OFF_ALIGN && w_strb[0]) begin
            soft_align_bit <= w_data[`COD_SOFT_ALIGN_BIT];
        end
    end

    // per-output ratio registers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_int
            wire [7:0] my_off = `COD_OFF_INTDIV0 + 8'(gi * 4);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    int_ratio[gi] <= 10'h001;
                end else if (do_write && w_off == my_off && w_strb[0]) begin
                    int_ratio[gi] <= w_data[9:0];
                end
            end
            // continuous ten-bit counter, cleared while alignment holds
            always_ff @(posedge aclk) begin
                if (!aresetn || hold_div) begin
                    int_cnt[gi] <= 10'h000;
                    int_out[gi] <= 1'b0;
                end else if (tick_sel[gi]) begin
                    int_cnt[gi] <= (int_cnt[gi] + 10'h001 >= int_ratio[gi]) ? 10'h000
                                   : int_cnt[gi] + 10'h001;
                    int_out[gi] <= (int_cnt[gi] < (int_ratio[gi] >> 1)) ||
                                   (int_ratio[gi] <= 10'h001);
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_frac
            wire [7:0] my_off = `COD_OFF_FRAC4 + 8'(gi * 4);
            // pre-divider in top byte, twenty-bit fraction below
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    frac_pre[gi] <= `COD_FRAC_MIN_PRE;
                    frac_val[gi] <= 20'h00000;
                end else if (do_write && w_off == my_off) begin
                    frac_pre[gi] <= w_data[31:24];
                    frac_val[gi] <= w_data[19:0];
                end
            end
            // fractional dividers on outputs four to seven
            cod_frac_div u_frac (
                .aclk    (aclk),
                .aresetn (aresetn),
                .hold    (hold_div),
                .pre_div (frac_pre[gi]),
                .frac    (frac_val[gi]),
                .tick_in (tick_sel[gi + 4]),
                .clk_out (frac_out[gi])
            );
        end
    endgenerate

    // prescaler edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= first_prescaler;
            prev_b <= second_prescaler;
        end
    end

    // alignment sequencer: hold, then retime release on first prescaler ticks
    always_comb begin
        next_align_state = align_state;
        case (align_state)
            COD_RUN:    if (align_req) next_align_state = COD_HOLD;
            COD_HOLD:   if (!align_req) next_align_state = COD_RETIME;
            COD_RETIME: begin
                if (align_req) next_align_state = COD_HOLD;
                else if (tick_a && retime_cnt >= 2'(`COD_FIRST_EDGE_CYC)) next_align_state = COD_RUN;
            end
            default:    next_align_state = COD_HOLD;
        endcase
    end

    // fixed retime count keeps the release delay deterministic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            align_state <= COD_HOLD;
            retime_cnt  <= 2'h0;
        end else begin
            align_state <= next_align_state;
            if (align_state != COD_RETIME) retime_cnt <= 2'h0;
            else if (tick_a && retime_cnt != 2'h3) retime_cnt <= retime_cnt + 2'h1;
        end
    end

    // output select: fractional or integer, then bypass on four and five
    logic [7:0] next_clk;
    always_comb begin
        next_clk = int_out;
        for (int i = 0; i < 4; i++) begin
            if (frac_enable[i]) next_clk[i + 4] = frac_out[i];
        end
        for (int i = 0; i < 2; i++) begin
            if (bypass_sel[i] == 2'(COD_BYP_PRI)) next_clk[i + 4] = primary_in;
            else if (bypass_sel[i] == 2'(COD_BYP_SEC)) next_clk[i + 4] = secondary_in;
        end
    end

    // outputs driven from flops; all enables release in one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out    <= 8'h00;
            clk_out_oe <= 8'h00;
        end else begin
            clk_out    <= hold_div ? 8'h00 : next_clk;
            clk_out_oe <= hold_div ? 8'h00 : out_enable;
        end
    end

    // read path; status shows alignment state and live outputs
    wire [4:0]  r_idx = r_off[6:2];
    wire [31:0] r_word =
        (r_off == `COD_OFF_CTRL)   ? {12'h000, bypass_sel[1], bypass_sel[0], 4'h0,
                                      frac_enable, out_enable} :
        (r_off == `COD_OFF_ALIGN)  ? {26'h0000000, soft_align_bit, 5'h00} :
        (r_off == `COD_OFF_STATUS) ? {14'h0000, align_state, clk_out_oe, clk_out} :
        (r_off >= `COD_OFF_INTDIV0 && r_off < 8'h60) ? {22'h000000, int_ratio[r_idx[2:0]]} :
        (r_off >= `COD_OFF_FRAC4 && r_off < 8'h70) ?
            {frac_pre[r_idx[1:0]], 4'h0, frac_val[r_idx[1:0]]} : 32'h00000000;
    wire r_hit = (r_off[1:0] == 2'b00) && ((r_off == `COD_OFF_CTRL) ||
                 (r_off == `COD_OFF_ALIGN) || (r_off == `COD_OFF_STATUS) ||
                 (r_off >= `COD_OFF_INTDIV0 && r_off < 8'h70));

    assign s_axi_arready = !s_axi_rvalid;

    // read answer one cycle after address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= r_word;
            s_axi_rresp  <= r_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    chk_hold_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_div |=> clk_out_oe == 8'h00) else $error("outputs driven during align");
    chk_align_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (align_req && align_state == COD_RUN) |=> align_state == COD_HOLD)
        else $error("align request not honoured");
    chk_release_retime: assert property (@(posedge aclk) disable iff (!aresetn)
        (align_state == COD_HOLD && !align_req) |=> align_state == COD_RETIME)
        else $error("release not latched");
    chk_either_source: assert property (@(posedge aclk) disable iff (!aresetn)
        (!output_align_request_n || soft_align_bit) |=> align_state == COD_HOLD)
        else $error("align source mismatch");
    chk_int_range: assert property (@(posedge aclk) disable iff (!aresetn)
        (int_ratio[0] > 10'h001) |-> int_cnt[0] < int_ratio[0])
        else $error("integer counter past ratio");
    chk_oe_together: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(align_state == COD_RUN) |=> clk_out_oe == out_enable)
        else $error("outputs not enabled together");
    chk_retime_exit: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(align_state == COD_RETIME) && align_state == COD_RUN |-> $past(tick_a))
        else $error("release not on first prescaler tick");
    chk_counter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        hold_div |=> int_cnt[2] == 10'h000) else $error("divider not reset");
endmodule

// >>> verification/cod_clk_rx.sv
// clock receiver model: counts live rising edges on each output
`timescale 1ns/1ps
module cod_clk_rx (
    input  wire logic       aclk,
    input  wire logic       clear,
    input  wire logic [7:0] clk_out,
    input  wire logic [7:0] clk_out_oe,
    output int              edges [8]
);
    logic [7:0] last;

    // a disabled output floats, so it neither counts nor keeps edge history
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 8; i++) begin
            if (clear) begin
                edges[i] <= 0;
            end else if (clk_out_oe[i] && clk_out[i] && !last[i]) begin
                edges[i] <= edges[i] + 1;
            end
            last[i] <= clk_out_oe[i] & clk_out[i];
        end
    end
endmodule

// >>> verification/clock_output_dividers_sync_test.sv
// self-checking bench for the clock output divider stage
`timescale 1ns/1ps
`include "cod_cfg.svh"
module clock_output_dividers_sync_test;
    import cod_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic        ps_a, ps_b, pri, sec, align_n, rx_clear;
    logic [7:0]  clk_out, clk_out_oe;
    int          edges [8];
    int          ratio [8];
    int          dly [2];
    int          mismatches, num_checks, ticks_a, ticks_b, rises_p, rises_s;

    cod_top i_cod_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .first_prescaler(ps_a), .second_prescaler(ps_b),
        .primary_in(pri), .secondary_in(sec), .output_align_request_n(align_n),
        .clk_out(clk_out), .clk_out_oe(clk_out_oe)
    );
    cod_clk_rx i_cod_clk_rx (
        .aclk(aclk), .clear(rx_clear), .clk_out(clk_out),
        .clk_out_oe(clk_out_oe), .edges(edges)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // prescaler and bypass inputs; second ones wander so ratios are not lock-step
    // first prescaler runs at one fixed rate, keeping the fractional input in band
    initial begin
        void'($urandom(41773));
        forever begin
            @(posedge aclk);
            ps_a <= ~ps_a;
            ticks_a <= rx_clear ? 0 : ticks_a + (ps_a ? 0 : 1);
            if ($urandom_range(1)) begin
                ps_b <= ~ps_b;
                ticks_b <= rx_clear ? 0 : ticks_b + (ps_b ? 0 : 1);
            end else if (rx_clear) ticks_b <= 0;
            if ($urandom_range(1)) begin
                pri <= ~pri;
                rises_p <= rx_clear ? 0 : rises_p + (pri ? 0 : 1);
            end else if (rx_clear) rises_p <= 0;
            if ($urandom_range(1)) begin
                sec <= ~sec;
                rises_s <= rx_clear ? 0 : rises_s + (sec ? 0 : 1);
            end else if (rx_clear) rises_s <= 0;
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic near(input int seen, input int exp, input int tol);
        check({31'h0, (seen >= exp - tol) && (seen <= exp + tol)}, 32'h1);
    endtask

    // both channels offered together, each dropped at the edge that takes it
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            da |= aw_ok;
            dw |= w_ok;
        end while (!(da && dw));
        do @(negedge aclk); while (!bvalid);
        resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rd = rdata;
        resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // model keeps the integer ratio of every output
    task automatic set_div(input int n, input int r);
        ratio[n] = r;
        axi_wr(`COD_OFF_INTDIV0 + 4 * n, r);
    endtask

    task automatic measure(input int cyc);
        @(posedge aclk);
        rx_clear <= 1'b1;
        @(posedge aclk);
        rx_clear <= 1'b0;
        repeat (cyc) @(posedge aclk);
        #1;
    endtask

    // bounded wait for release; outputs must never come up one by one
    task automatic wait_on(output int d);
        d = 0;
        do begin
            @(posedge aclk);
            #1;
            d++;
            if (clk_out_oe !== 8'h00 && clk_out_oe !== 8'hFF) check(clk_out_oe, 8'hFF);
        end while (clk_out_oe !== 8'hFF && d < 40);
        check(clk_out_oe, 8'hFF);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_clear} = 7'h00;
        {ps_a, ps_b, pri, sec, align_n} = 5'h01;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hF;
        {mismatches, num_checks, ticks_a, ticks_b, rises_p, rises_s} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`COD_OFF_CTRL);
        check(rd, 32'h0);
        check({30'h0, resp}, 32'h0);
        axi_rd(`COD_OFF_INTDIV0);
        check({22'h0, rd[9:0]}, 32'h1);
        axi_rd(32'h04);
        check({30'h0, resp}, 32'h2);
        check(rd, 32'h0);
        // outputs brought up one at a time, as a sequencing host does
        for (int i = 0; i < 8; i++) begin
            axi_wr(`COD_OFF_CTRL, (32'h2 << i) - 1);
            check({30'h0, resp}, 32'h0);
            repeat (3) @(posedge aclk);
            check(clk_out_oe, (8'h2 << i) - 1);
        end
        set_div(0, 3);
        set_div(2, 5);
        set_div(4, 6);
        measure(600);
        near(edges[0], ticks_a / ratio[0], 2);
        near(edges[2], ticks_b / ratio[2], 2);
        near(edges[4], ticks_a / ratio[4], 2);
        axi_wr(`COD_OFF_CTRL, 32'h1FF);
        axi_wr(`COD_OFF_FRAC4, 32'h0408_0000);
        axi_rd(`COD_OFF_FRAC4);
        check(rd, 32'h0408_0000);
        measure(900);
        near(edges[4], ticks_a * 2 / 9, 3);
        axi_wr(`COD_OFF_FRAC4, 32'h0100_0000);
        measure(600);
        near(edges[4], ticks_a / 2, 3);
        for (int s = 1; s < 3; s++) begin
            axi_wr(`COD_OFF_CTRL, 32'hFF | (s << 18));
            measure(400);
            near(edges[5], (s == 1) ? rises_p : rises_s, 2);
        end
        axi_wr(`COD_OFF_CTRL, 32'hFF);
        // pin held low twice; release delay must repeat
        for (int k = 0; k < 2; k++) begin
            @(posedge aclk);
            align_n <= 1'b0;
            measure(30);
            check(clk_out_oe, 8'h00);
            for (int i = 0; i < 8; i++) near(edges[i], 0, 0);
            axi_rd(`COD_OFF_STATUS);
            check({30'h0, rd[17:16]}, 32'h1);
            @(posedge aclk);
            align_n <= 1'b1;
            wait_on(dly[k]);
        end
        near(dly[0], dly[1], 2);
        axi_wr(`COD_OFF_ALIGN, 32'h20);
        repeat (3) @(posedge aclk);
        check(clk_out_oe, 8'h00);
        @(posedge aclk);
        align_n <= 1'b0;
        axi_wr(`COD_OFF_ALIGN, 32'h00);
        repeat (4) @(posedge aclk);
        check(clk_out_oe, 8'h00);
        align_n <= 1'b1;
        wait_on(dly[0]);
        final_report();
    end

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        final_report();
    end
endmodule
